// [rtl/rx_stats_map.vh]
// Register offsets, field positions and reset values of the statistics monitor.
`ifndef RX_STATS_MAP_VH
`define RX_STATS_MAP_VH

// Byte offsets of the register words on the bus.
`define OFS_CONFIG    8'h00
`define OFS_TXSTAT    8'h04
`define OFS_RXSTAT    8'h08
`define OFS_INTSTAT   8'h0c
`define OFS_INTMASK   8'h10
`define OFS_CNT_BASE  8'h20

// Configuration word fields.
`define CFG_PROMISC   0
`define CFG_MON_LO    1
`define CFG_MON_HI    2
`define CFG_SAVEBAD   3
`define CFG_LOOP_LO   4
`define CFG_LOOP_HI   5
`define CFG_MINLEN_LO 8
`define CFG_MINLEN_HI 15
`define CFG_USED      32'h0000ff3f
`define CONFIG_RESET  32'h00004000

// Monitor mode encodings.
`define MON_OFF       2'h0
`define MON_OPT1      2'h1
`define MON_OPT2      2'h2
`define MON_OPT3      2'h3
`define LOOP_EXTERNAL 2'h3

// Absolute minimum frame lengths in bytes.
`define ABS_MIN_LEN   16'h0005
`define ABS_MIN_MCAST 16'h0006

// Statistics counter indices.
`define CNT_CRC       0
`define CNT_ALIGN     1
`define CNT_NORES     2
`define CNT_OVERRUN   3
`define CNT_COLL      4
`define CNT_SHORT     5
`define CNT_TOTAL     6
`define CNT_GOOD      7
`define NUM_CNT       8

// Counters kept in each monitor mode.
`define MASK_NORMAL   8'h3f
`define MASK_OPT1     8'haf
`define MASK_OPT23    8'hf3

// Interrupt status bits.
`define INT_RXDONE    0
`define INT_TXDONE    1
`define INT_RXERR     2
`define INT_TRUNC     3
`define INT_USED      4'hf

// Bus responses.
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// [rtl/stat_counter_bank.v]
// Bank of free-running statistics counters with per-counter increment and clear.
`timescale 1ns/100ps
module stat_counter_bank #(
  parameter NUM   = 8,
  parameter WIDTH = 32
) (
  // Clock and reset.
  input  wire                 clk,
  input  wire                 rst_b,
  // One-cycle increment and clear strobes.
  input  wire [NUM-1:0]       inc,
  input  wire [NUM-1:0]       clr,
  // Counter values, counter i in bits [i*WIDTH +: WIDTH].
  output wire [NUM*WIDTH-1:0] cntFlat
);

  genvar i;

  generate
    for (i = 0; i < NUM; i = i + 1)
    begin : gCnt
      reg [WIDTH-1:0] cnt_q;  // Counter state.

      // A clear that meets an increment leaves one, so the frame is not lost.
      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          cnt_q <= {WIDTH{1'b0}};
        else if (clr[i])
          cnt_q <= {{(WIDTH-1){1'b0}}, inc[i]};
        else if (inc[i])
          cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end

      assign cntFlat[i*WIDTH +: WIDTH] = cnt_q;
    end
  endgenerate

endmodule // stat_counter_bank

// [rtl/frame_classifier.v]
// Per-frame decision logic: which counters move, whether to store or truncate.
`timescale 1ns/100ps
`include "rx_stats_map.vh"
module frame_classifier (
  // Configuration.
  input  wire        promisc,
  input  wire [1:0]  monMode,
  input  wire        saveBad,
  input  wire [7:0]  minLen,
  // Frame facts at its end.
  input  wire [15:0] len,
  input  wire [15:0] space,
  input  wire        addrMatch,
  input  wire        multicast,
  input  wire        sfdSeen,
  input  wire        crcBad,
  input  wire        misaligned,
  input  wire        noRes,
  input  wire        overrun,
  input  wire        coll,
  input  wire        collPre,
  input  wire        lenMismatch,
  // Decisions.
  output wire [7:0]  inc,
  output wire        store,
  output wire        trunc,
  output wire [6:0]  errBits
);

  reg  [7:0] modeMask;  // Counters kept in the current mode.
  wire       pass;      // Frame passes address filtering.
  wire       absOk;     // Delimiter seen and above absolute minimum.
  wire       elig;      // Frame may touch counters.
  wire       long;      // Frame exceeds configured minimum.
  wire       good;      // Frame free of CRC, resource, overrun and collision errors.
  wire [7:0] raw;       // Counter hits before masking.

  // Promiscuous capture skips the destination check.
  assign pass  = promisc | addrMatch;
  assign absOk = sfdSeen & (len > (multicast ? `ABS_MIN_MCAST : `ABS_MIN_LEN));
  // The third option looks at every frame, delimiter or not.
  assign elig  = (monMode == `MON_OPT3) | (pass & absOk);
  assign long  = len > {8'h00, minLen};
  assign good  = ~crcBad & ~noRes & ~overrun & ~coll;

  // Counter selection per monitor mode.
  always @*
  begin
    case (monMode)
      `MON_OPT1: modeMask = `MASK_OPT1;
      `MON_OPT2: modeMask = `MASK_OPT23;
      `MON_OPT3: modeMask = `MASK_OPT23;
      default:   modeMask = `MASK_NORMAL;
    endcase
  end

  assign raw[`CNT_CRC]     = long & crcBad & ~misaligned;
  assign raw[`CNT_ALIGN]   = long & crcBad & misaligned;
  assign raw[`CNT_NORES]   = long & noRes;
  assign raw[`CNT_OVERRUN] = long & overrun;
  // Short collisions fall to the short counter; preamble ones vanish.
  assign raw[`CNT_COLL]    = long & coll & ~collPre;
  assign raw[`CNT_SHORT]   = ~long;
  assign raw[`CNT_TOTAL]   = long;
  assign raw[`CNT_GOOD]    = long & good;

  assign inc = elig ? (raw & modeMask) : 8'h00;

  // Options two and three disable storage; option one stores good frames only.
  assign store = ~monMode[1] & pass & absOk &
                 ((long & good) | (saveBad & ~monMode[0]));
  assign trunc = store & (len > space);

  // Error report is kept only when bad frames are saved.
  assign errBits = saveBad ? {lenMismatch, coll & ~collPre, noRes, overrun, ~long,
                              crcBad & misaligned, crcBad & ~misaligned} : 7'h00;

endmodule // frame_classifier

// [rtl/lan_rx_statistics_monitor.v]
// Network statistics monitor with AXI4-Lite register access and interrupt.
`timescale 1ns/100ps
`include "rx_stats_map.vh"
// Overview of operation
// - Record collision count in transmit status.
// - Flag deferred first attempt in transmit status.
// - Outside option three, counters move only for passing frames with delimiter above absolute minimum.
// - CRC or alignment counter by frame alignment.
// - Count frames dropped for lack of storage.
// - Count frames partly stored by bus overrun.
// - Count receive collisions; short ones, preamble excluded.
// - Count frames at or below configured minimum length.
// - No counter change before address match, except in option three.
// - Promiscuous mode skips destination address check.
// - Oversized frame truncated, status updated, next descriptor.
// - Normal reception needs delimiter and minimum bytes.
// - Two bits pick three monitor options.
// - Option one stores good, six counters.
// - Option two disables reception, filtered frames.
// - Option three disables reception, all frames.
// - Loopback bits 11 drive external loop output.
// - Save bad frames reports all error kinds.
module lan_rx_statistics_monitor #(
  parameter ADDR_W = 8,
  parameter CNT_W  = 32
) (
  // Clock and reset.
  input  wire              clk,
  input  wire              rst_b,
  // AXI4-Lite write address channel.
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // AXI4-Lite write response channel.
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // AXI4-Lite read data channel.
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  // Receive frame report from the serial side.
  input  wire              rxFrameEnd,
  input  wire [15:0]       rxLength,
  input  wire [15:0]       rxDescSpace,
  input  wire              rxAddrMatch,
  input  wire              rxMulticast,
  input  wire              rxSfdSeen,
  input  wire              rxCrcBad,
  input  wire              rxMisaligned,
  input  wire              rxNoResource,
  input  wire              rxOverrun,
  input  wire              rxCollision,
  input  wire              rxCollPreamble,
  input  wire              rxLengthMismatch,
  // Transmit frame report.
  input  wire              txFrameDone,
  input  wire [3:0]        txCollisions,
  input  wire              txDeferred,
  // Receive decisions toward the memory side.
  output wire              rxStoreFrame,
  output wire              rxTruncate,
  output wire              rxNextDescriptor,
  output wire [8:0]        rxFrameStatus,
  output wire [4:0]        txFrameStatus,
  // Pins and interrupt.
  output wire              external_loop_output,
  output wire              irq
);

  // Write channel state.
  reg  [ADDR_W-1:0] awAddr_q;     // Captured write address.
  reg               awHeld_q;     // Write address is held.
  reg  [31:0]       wData_q;      // Captured write data.
  reg  [3:0]        wStrb_q;      // Captured byte strobes.
  reg               wHeld_q;      // Write data is held.
  reg               bValid_q;     // Write response pending.
  reg  [1:0]        bResp_q;      // Write response code.
  // Read channel state.
  reg               rValid_q;     // Read data pending.
  reg  [31:0]       rData_q;      // Read data.
  reg  [1:0]        rResp_q;      // Read response code.
  reg  [31:0]       rdMux;        // Combinational read value.
  reg               rdHit;        // Read address is mapped.
  reg               wrHit;        // Write address is mapped.
  // Registers.
  reg  [31:0]       config_q;     // Configuration word.
  reg  [3:0]        intStat_q;    // Sticky interrupt events.
  reg  [3:0]        intMask_q;    // Interrupt enables.
  reg  [8:0]        rxStat_q;     // Last receive frame status.
  reg  [4:0]        txStat_q;     // Last transmit frame status.
  reg  [7:0]        incPulse_q;   // Counter increments for the frame.
  reg               store_q;      // Store strobe.
  reg               trunc_q;      // Truncate strobe.
  reg               extLoop_q;    // External loopback pin.
  reg  [3:0]        intStat_d;    // Next interrupt status.
  // Decoded signals.
  wire              doWrite;      // Held write is performed now.
  wire [31:0]       wMask;        // Byte-enable bit mask.
  wire [7:0]        cntClr;       // Counter clear strobes.
  wire [7:0]        frameInc;     // Classifier counter hits.
  wire              frameStore;   // Classifier store decision.
  wire              frameTrunc;   // Classifier truncate decision.
  wire [6:0]        frameErr;     // Classifier error bits.
  wire [3:0]        intEvt;       // Events this cycle.
  wire [3:0]        intClr;       // Write-one-clear bits.
  wire [8*CNT_W-1:0] cntFlat;     // Counter values.

  // True when an address falls in the counter window.
  function isCntAddr;
    input [ADDR_W-1:0] a;
    begin
      isCntAddr = (a[7:5] == `OFS_CNT_BASE >> 5);
    end
  endfunction

  // Expands byte strobes to a bit mask.
  function [31:0] strbMask;
    input [3:0] s;
    begin
      strbMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // Address and data are taken independently; both wait while a response is owed.
  assign s_axi_awready = ~awHeld_q & ~bValid_q;
  assign s_axi_wready  = ~wHeld_q & ~bValid_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign doWrite       = awHeld_q & wHeld_q & ~bValid_q;
  assign wMask         = strbMask(wStrb_q);

  // Write channel capture and response.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      awAddr_q <= {ADDR_W{1'b0}};
      awHeld_q <= 1'b0;
      wData_q  <= 32'h00000000;
      wStrb_q  <= 4'h0;
      wHeld_q  <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q  <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_q <= s_axi_awaddr;
        awHeld_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHeld_q <= 1'b1;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= wrHit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bValid_q && s_axi_bready)
        bValid_q <= 1'b0;
    end
  end

  // Write address decode; transmit and receive status words are read-only but answer OKAY.
  always @*
  begin
    if (awAddr_q == `OFS_CONFIG)
      wrHit = 1'b1;
    else if (awAddr_q == `OFS_TXSTAT)
      wrHit = 1'b1;
    else if (awAddr_q == `OFS_RXSTAT)
      wrHit = 1'b1;
    else if (awAddr_q == `OFS_INTSTAT)
      wrHit = 1'b1;
    else if (awAddr_q == `OFS_INTMASK)
      wrHit = 1'b1;
    else if (isCntAddr(awAddr_q) && (awAddr_q[1:0] == 2'h0))
      wrHit = 1'b1;
    else
      wrHit = 1'b0;
  end

  // A write of any value to a counter word clears that counter.
  genvar g;
  generate
    for (g = 0; g < `NUM_CNT; g = g + 1)
    begin : gClr
      assign cntClr[g] = doWrite & isCntAddr(awAddr_q) & (awAddr_q[4:2] == g) &
                         (awAddr_q[1:0] == 2'h0) & (|wStrb_q);
    end
  endgenerate

  // Configuration and mask registers honour byte strobes.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      config_q  <= `CONFIG_RESET;
      intMask_q <= 4'h0;
      extLoop_q <= 1'b0;
    end
    else
    begin
      if (doWrite && (awAddr_q == `OFS_CONFIG))
        config_q <= ((config_q & ~wMask) | (wData_q & wMask)) & `CFG_USED;
      if (doWrite && (awAddr_q == `OFS_INTMASK))
        intMask_q <= (intMask_q & ~wMask[3:0]) | (wData_q[3:0] & wMask[3:0]);
      // Both loopback bits set select the external loop.
      extLoop_q <= (config_q[`CFG_LOOP_HI:`CFG_LOOP_LO] == `LOOP_EXTERNAL);
    end
  end

  // Frame decision logic.
  frame_classifier uClass (
    .promisc     (config_q[`CFG_PROMISC]),
    .monMode     (config_q[`CFG_MON_HI:`CFG_MON_LO]),
    .saveBad     (config_q[`CFG_SAVEBAD]),
    .minLen      (config_q[`CFG_MINLEN_HI:`CFG_MINLEN_LO]),
    .len         (rxLength),
    .space       (rxDescSpace),
    .addrMatch   (rxAddrMatch),
    .multicast   (rxMulticast),
    .sfdSeen     (rxSfdSeen),
    .crcBad      (rxCrcBad),
    .misaligned  (rxMisaligned),
    .noRes       (rxNoResource),
    .overrun     (rxOverrun),
    .coll        (rxCollision),
    .collPre     (rxCollPreamble),
    .lenMismatch (rxLengthMismatch),
    .inc         (frameInc),
    .store       (frameStore),
    .trunc       (frameTrunc),
    .errBits     (frameErr)
  );

  // Frame end is a single strobe, so each counter sees at most one pulse per frame.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      incPulse_q <= 8'h00;
      store_q    <= 1'b0;
      trunc_q    <= 1'b0;
      rxStat_q   <= 9'h000;
      txStat_q   <= 5'h00;
    end
    else
    begin
      incPulse_q <= rxFrameEnd ? frameInc : 8'h00;
      store_q    <= rxFrameEnd & frameStore;
      trunc_q    <= rxFrameEnd & frameTrunc;
      if (rxFrameEnd)
        rxStat_q <= {frameTrunc, frameStore, frameErr};
      if (txFrameDone)
        txStat_q <= {txDeferred, txCollisions};
    end
  end

  assign rxStoreFrame     = store_q;
  assign rxTruncate       = trunc_q;
  // A stored frame always moves on to a fresh descriptor.
  assign rxNextDescriptor = store_q;
  assign rxFrameStatus    = rxStat_q;
  assign txFrameStatus    = txStat_q;
  assign external_loop_output = extLoop_q;

  // Statistics counters.
  stat_counter_bank #(
    .NUM   (`NUM_CNT),
    .WIDTH (CNT_W)
  ) uCnt (
    .clk     (clk),
    .rst_b   (rst_b),
    .inc     (incPulse_q),
    .clr     (cntClr),
    .cntFlat (cntFlat)
  );

  // Receive interrupt events are taken from the registered frame strobes; transmit done comes straight from txFrameDone.
  assign intEvt[`INT_RXDONE] = store_q | (|incPulse_q);
  assign intEvt[`INT_TXDONE] = txFrameDone;
  assign intEvt[`INT_RXERR]  = store_q & (|rxStat_q[6:0]);
  assign intEvt[`INT_TRUNC]  = trunc_q;
  assign intClr = (doWrite && (awAddr_q == `OFS_INTSTAT)) ?
                  (wData_q[3:0] & wMask[3:0]) : 4'h0;

  // Sticky status; a new event beats a clear in the same cycle.
  always @*
  begin
    intStat_d = ((intStat_q & ~intClr) | intEvt) & `INT_USED;
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      intStat_q <= 4'h0;
    else
      intStat_q <= intStat_d;
  end

  assign irq = |(intStat_q & intMask_q);

  // Read channel: one pending answer, address taken only when idle.
  assign s_axi_arready = ~rValid_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;

  // Read address decode.
  always @*
  begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    if (s_axi_araddr == `OFS_CONFIG)
      rdMux = config_q;
    else if (s_axi_araddr == `OFS_TXSTAT)
      rdMux = {27'h0000000, txStat_q};
    else if (s_axi_araddr == `OFS_RXSTAT)
      rdMux = {23'h000000, rxStat_q};
    else if (s_axi_araddr == `OFS_INTSTAT)
      rdMux = {28'h0000000, intStat_q};
    else if (s_axi_araddr == `OFS_INTMASK)
      rdMux = {28'h0000000, intMask_q};
    else if (isCntAddr(s_axi_araddr) && (s_axi_araddr[1:0] == 2'h0))
      rdMux = cntFlat[s_axi_araddr[4:2]*CNT_W +: 32];
    else
      rdHit = 1'b0;
  end

  // Read data is registered at the address handshake.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h00000000;
      rResp_q  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rValid_q <= 1'b1;
      rData_q  <= rdMux;
      rResp_q  <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rValid_q && s_axi_rready)
      rValid_q <= 1'b0;
  end

endmodule // lan_rx_statistics_monitor

// [sim/serial_medium_model.sv]
// Far-side model: the serial front end reporting each received and sent frame.
`timescale 1ns/100ps
module serial_medium_model (
  // Clock.
  input  wire         clk,
  // Receive frame report, flags in the order of the frame table.
  output logic        rxFrameEnd,
  output logic [15:0] rxLength,
  output logic [15:0] rxDescSpace,
  output logic [9:0]  rxFlags,
  // Transmit frame report.
  output logic        txFrameDone,
  output logic [3:0]  txCollisions,
  output logic        txDeferred
);
  // Facts are garbage outside a report, so stale values cannot pass.
  initial
  begin
    rxFrameEnd = 1'b0;
    txFrameDone = 1'b0;
    {rxLength, rxDescSpace, rxFlags, txCollisions, txDeferred} = '1;
  end

  // One frame end, facts held for that cycle and inverted after it.
  task automatic sendFrame(input logic [15:0] len, space, input logic [9:0] fl);
    @(posedge clk);
    rxFrameEnd <= 1'b1;
    {rxLength, rxDescSpace, rxFlags} <= {len, space, fl};
    @(posedge clk);
    rxFrameEnd <= 1'b0;
    {rxLength, rxDescSpace, rxFlags} <= ~{len, space, fl};
  endtask

  // One transmit report.
  task automatic sendTx(input logic [3:0] coll, input logic dfr);
    @(posedge clk);
    txFrameDone <= 1'b1;
    {txCollisions, txDeferred} <= {coll, dfr};
    @(posedge clk);
    txFrameDone <= 1'b0;
    {txCollisions, txDeferred} <= ~{coll, dfr};
  endtask
endmodule // serial_medium_model

// [sim/lan_rx_statistics_monitor_sva.sv]
// Concurrent checks on the monitor's frame decisions, status words and loop pin.
`timescale 1ns/100ps
module lan_rx_statistics_monitor_sva (
  // Clock and reset.
  input wire        clk,
  input wire        rst_b,
  // Bus write answer.
  input wire        s_axi_bvalid,
  // Frame reports.
  input wire        rxFrameEnd,
  input wire [15:0] rxLength,
  input wire [15:0] rxDescSpace,
  input wire        rxSfdSeen,
  input wire        txFrameDone,
  input wire [3:0]  txCollisions,
  input wire        txDeferred,
  // Decisions and pins.
  input wire        rxStoreFrame,
  input wire        rxTruncate,
  input wire        rxNextDescriptor,
  input wire [8:0]  rxFrameStatus,
  input wire [4:0]  txFrameStatus,
  input wire        external_loop_output
);
  // Single clock domain, so both are stated once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A frame end without a start delimiter.
  sequence noSfdEnd;
    rxFrameEnd && !rxSfdSeen;
  endsequence

  // A frame end at or below the absolute minimum length.
  sequence tinyEnd;
    rxFrameEnd && rxLength <= 16'h0005;
  endsequence

  a_next_desc_pair: assert property (rxNextDescriptor == rxStoreFrame)
    else $error("next descriptor differs from store");
  a_trunc_cause: assert property (rxTruncate |-> rxStoreFrame &&
    $past(rxLength) > $past(rxDescSpace))
    else $error("truncation without oversized store");
  a_store_no_sfd: assert property (noSfdEnd |=> !rxStoreFrame)
    else $error("stored frame lacks delimiter");
  a_store_tiny: assert property (tinyEnd |=> !rxStoreFrame)
    else $error("stored frame too short");
  a_store_cause: assert property (rxStoreFrame |-> $past(rxFrameEnd))
    else $error("store without frame end");
  a_rx_status_hold: assert property (!rxFrameEnd |=> $stable(rxFrameStatus))
    else $error("receive status moved alone");
  a_tx_status_load: assert property (txFrameDone |=>
    txFrameStatus == {$past(txDeferred), $past(txCollisions)})
    else $error("wrong transmit status");
  a_tx_status_hold: assert property (!txFrameDone |=> $stable(txFrameStatus))
    else $error("transmit status moved alone");
  a_loop_cause: assert property ($changed(external_loop_output) |-> $past(s_axi_bvalid))
    else $error("loop pin moved without write");
endmodule // lan_rx_statistics_monitor_sva

bind lan_rx_statistics_monitor lan_rx_statistics_monitor_sva chk_u (.*);

// [sim/lan_rx_statistics_monitor_tb.sv]
// Self-checking bench for the receive statistics monitor.
`timescale 1ns/100ps
`include "rx_stats_map.vh"
module lan_rx_statistics_monitor_tb;
  // Row: config byte, length, flags, counter moves, expected status.
  typedef struct {
    logic [7:0] cfg;
    logic [7:0] len;
    logic [9:0] fl;
    logic [7:0] inc;
    logic [8:0] st;
  } row_t;
  // Flags: 1 match, 2 multicast, 4 delimiter, 8 crc, 10 misaligned, 20 no room,
  // 40 overrun, 80 collision, 100 collision in preamble, 200 length mismatch.
  row_t rows [22] = '{
    '{8'h00, 8'h40, 10'h005, 8'h00, 9'h080},
    '{8'h00, 8'h40, 10'h00d, 8'h01, 9'h000},
    '{8'h00, 8'h40, 10'h01d, 8'h02, 9'h000},
    '{8'h00, 8'h40, 10'h025, 8'h04, 9'h000},
    '{8'h00, 8'h40, 10'h045, 8'h08, 9'h000},
    '{8'h00, 8'h40, 10'h085, 8'h10, 9'h000},
    '{8'h00, 8'h40, 10'h185, 8'h00, 9'h000},
    '{8'h00, 8'h10, 10'h085, 8'h20, 9'h000},
    '{8'h00, 8'h40, 10'h00c, 8'h00, 9'h000},
    '{8'h01, 8'h40, 10'h00c, 8'h01, 9'h000},
    '{8'h00, 8'h05, 10'h005, 8'h00, 9'h000},
    '{8'h00, 8'h06, 10'h007, 8'h00, 9'h000},
    '{8'h00, 8'h06, 10'h005, 8'h20, 9'h000},
    '{8'h00, 8'h40, 10'h009, 8'h00, 9'h000},
    '{8'h02, 8'h40, 10'h005, 8'h80, 9'h080},
    '{8'h02, 8'h40, 10'h085, 8'h00, 9'h000},
    '{8'h04, 8'h40, 10'h005, 8'hc0, 9'h000},
    '{8'h04, 8'h40, 10'h00d, 8'h41, 9'h000},
    '{8'h06, 8'h40, 10'h080, 8'h50, 9'h000},
    '{8'h06, 8'h08, 10'h000, 8'h20, 9'h000},
    '{8'h08, 8'h40, 10'h00d, 8'h01, 9'h081},
    '{8'h08, 8'h40, 10'h205, 8'h00, 9'h0c0}
  };
  logic        clk, rst_b;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         rxFrameEnd, txFrameDone, txDeferred, rxStoreFrame, rxTruncate;
  wire         rxNextDescriptor, external_loop_output, irq;
  wire  [15:0] rxLength, rxDescSpace;
  wire  [9:0]  rxFlags;
  wire  [3:0]  txCollisions;
  wire  [8:0]  rxFrameStatus;
  wire  [4:0]  txFrameStatus;
  int          fail_count, comparisons, cycles;
  logic [31:0] expCnt [8];
  logic [31:0] rdData;
  logic [1:0]  rdResp;

  lan_rx_statistics_monitor dut_u (
    .*, .rxAddrMatch(rxFlags[0]), .rxMulticast(rxFlags[1]), .rxSfdSeen(rxFlags[2]),
    .rxCrcBad(rxFlags[3]), .rxMisaligned(rxFlags[4]), .rxNoResource(rxFlags[5]),
    .rxOverrun(rxFlags[6]), .rxCollision(rxFlags[7]), .rxCollPreamble(rxFlags[8]),
    .rxLengthMismatch(rxFlags[9])
  );

  serial_medium_model medium_u (.*);

  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // A hang counts as a mismatch; about eight hundred cycles are needed.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input string what, logic [31:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Readiness is looked at mid-cycle, where it equals its value at the next edge.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    logic aTk, wTk, bTk;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(negedge clk);
      {aTk, wTk, bTk, rdResp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge clk);
      if (aTk) s_axi_awvalid <= 1'b0;
      if (wTk) s_axi_wvalid <= 1'b0;
    end
    while (!bTk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a);
    logic arTk, rTk;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(negedge clk);
      {arTk, rTk, rdData, rdResp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (arTk) s_axi_arvalid <= 1'b0;
    end
    while (!rTk);
    s_axi_rready <= 1'b0;
  endtask

  // Configure, send a frame, check pulses, status and counters.
  task automatic doFrame(input row_t r, input logic [15:0] space);
    axiWrite(`OFS_CONFIG, {16'h0000, 8'h10, r.cfg});
    medium_u.sendFrame({8'h00, r.len}, space, r.fl);
    #1;
    chk("store pulse", {31'h0, r.st[7]}, {31'h0, rxStoreFrame});
    chk("truncate pulse", {31'h0, r.st[8]}, {31'h0, rxTruncate});
    chk("frame status", {23'h0, r.st}, {23'h0, rxFrameStatus});
    for (int i = 0; i < 8; i++)
    begin
      expCnt[i] += {31'h0, r.inc[i]};
      axiRead(8'h20 + 8'(4 * i));
      chk("counter", expCnt[i], rdData);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence: reset, frame table, then truncation, interrupts, transmit, pins.
  initial
  begin
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    foreach (expCnt[k]) expCnt[k] = 32'h0;
    repeat (2) @(posedge clk);
    chk("irq in reset", 32'h0, {31'h0, irq});
    chk("loop pin in reset", 32'h0, {31'h0, external_loop_output});
    rst_b <= 1'b1;
    axiRead(`OFS_CONFIG);
    chk("config reset", `CONFIG_RESET, rdData);
    foreach (rows[k]) doFrame(rows[k], 16'h0040);
    doFrame('{8'h09, 8'h64, 10'h004, 8'h00, 9'h180}, 16'h0014);
    axiWrite(`OFS_INTSTAT, 32'h0000000f);
    axiWrite(`OFS_INTMASK, 32'h00000000);
    doFrame(rows[0], 16'h0040);
    chk("irq masked", 32'h0, {31'h0, irq});
    axiRead(`OFS_INTSTAT);
    chk("interrupt status", 32'h1, rdData);
    axiWrite(`OFS_INTMASK, 32'h00000001);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    axiWrite(`OFS_INTSTAT, 32'h00000001);
    chk("irq cleared", 32'h0, {31'h0, irq});
    medium_u.sendTx(4'h3, 1'b1);
    #1;
    chk("tx status", 32'h13, {27'h0, txFrameStatus});
    axiRead(`OFS_TXSTAT);
    chk("tx status word", 32'h13, rdData);
    axiWrite(`OFS_CONFIG, 32'h00001030);
    repeat (2) @(posedge clk);
    chk("loop pin on", 32'h1, {31'h0, external_loop_output});
    axiWrite(`OFS_CONFIG, 32'h00001020);
    repeat (2) @(posedge clk);
    chk("loop pin off", 32'h0, {31'h0, external_loop_output});
    axiWrite(`OFS_CNT_BASE, 32'h0);
    axiRead(`OFS_CNT_BASE);
    chk("cleared counter", 32'h0, rdData);
    axiRead(8'h1c);
    chk("unmapped response", {30'h0, `RESP_SLVERR}, {30'h0, rdResp});
    axiWrite(8'h1c, 32'h0);
    chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, rdResp});
    end_of_test();
  end
endmodule // lan_rx_statistics_monitor_tb
